// file: inc/fwr_pkg.sv
// Shared constants and types for the fault waveform recorder
`default_nettype none
package fwr_pkg;
  // Sampling: 20 samples per 50 Hz power cycle gives one sample per ms
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SYS_HZ = 50;
  localparam int unsigned SMP_PER_CYCLE = 20;
  localparam int unsigned SAMPLE_US = 1_000_000 / (SYS_HZ * SMP_PER_CYCLE);
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
  // Store limits; all settings below are in ms, equal to samples
  localparam int unsigned REC_MAX = 8;
  localparam int unsigned TOTAL_MS = 15000;
  localparam int unsigned MEM_DEPTH = TOTAL_MS * 1000 / SAMPLE_US;
  localparam int unsigned CAP_MS = 5000;
  localparam int unsigned PRE_MIN_MS = 50;
  localparam int unsigned PRE_MAX_MS = 500;
  localparam int unsigned PRE_DEF_MS = 250;
  localparam int unsigned POST_MIN_MS = 50;
  localparam int unsigned POST_MAX_MS = 500;
  localparam int unsigned POST_DEF_MS = 100;
  localparam int unsigned MAXL_MIN_MS = 300;
  localparam int unsigned MAXL_DEF_MS = 2000;
  localparam int unsigned EXT_MIN_MS = 100;
  localparam int unsigned EXT_DEF_MS = 500;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRE = 8'h04;
  localparam logic [7:0] OFS_POST = 8'h08;
  localparam logic [7:0] OFS_MAXL = 8'h0c;
  localparam logic [7:0] OFS_EXT = 8'h10;
  localparam logic [7:0] OFS_STS = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_INFO = 8'h1c;
  localparam logic [7:0] OFS_RSEL = 8'h20;
  localparam logic [7:0] OFS_SIDX = 8'h24;
  localparam logic [7:0] OFS_RLEN = 8'h28;
  localparam logic [7:0] OFS_D0 = 8'h2c;
  localparam logic [7:0] OFS_D1 = 8'h30;
  localparam logic [7:0] OFS_D2 = 8'h34;
  // Field positions
  localparam int unsigned CTRL_SCOPE = 2;
  localparam int unsigned CTRL_XTRIP = 3;
  localparam int unsigned CTRL_SWTRIG = 4;
  localparam int unsigned STS_DONE = 0;
  localparam int unsigned STS_DROP = 1;
  localparam int unsigned STS_XFER = 2;
  localparam int unsigned STS_W = 3;
  localparam int unsigned INFO_ACTIVE = 8;
  typedef enum logic [1:0] {
    MODE_SAVE_PU = 2'h0,
    MODE_SAVE_TRIP = 2'h1,
    MODE_START_TRIP = 2'h2
  } fwr_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FAULT = 2'h1,
    ST_POST = 2'h2
  } fwr_state_t;
endpackage
`default_nettype wire

// file: hdl/fwr_top.sv
// Fault waveform recorder with APB register access
//
// Overview of operation
// - Sample six channels every millisecond
// - Single record never exceeds five seconds
// - At most eight records, fifteen seconds
// - Store updates itself without reader acknowledge
// - Start by pickup, binary input, serial
// - Trigger instant separate from save criterion
// - Mode: save pickup, save trip, start trip
// - Single scope: first pickup to last dropout
// - Whole scope spans reclose dead times
// - Record starts pre-trigger interval before trigger
// - Record ends post interval after criterion
// - Maximum record length setting stops recording
// - External triggers use external capture duration
// - Infinite duration follows binary input level
// - Recording-active output while capturing
// - Transfer request after fault or trip
// - Reader retrieves completed records over bus
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fwr_top #(
  parameter int unsigned TICK_CYC = fwr_pkg::TICK_CYC,
  parameter int unsigned DEPTH = fwr_pkg::MEM_DEPTH,
  parameter int unsigned NREC = fwr_pkg::REC_MAX,
  parameter int unsigned DW = 16
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [DW-1:0] cur_l1_i,
  input wire logic [DW-1:0] cur_l2_i,
  input wire logic [DW-1:0] cur_l3_i,
  input wire logic [DW-1:0] vol_l1_i,
  input wire logic [DW-1:0] vol_l2_i,
  input wire logic [DW-1:0] vol_l3_i,
  input wire logic pickup_i,
  input wire logic trip_i,
  input wire logic reclose_i,
  input wire logic bin_trig_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic rec_active_o,
  output logic rec_start_o,
  output logic xfer_req_o,
  output logic irq_o
);
  localparam int unsigned LW = $clog2(fwr_pkg::CAP_MS + 1);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned IW = $clog2(NREC);
  localparam int unsigned TW = $clog2(TICK_CYC);
  localparam int unsigned SW = 6 * DW;

  typedef struct packed {
    logic [DEPTH-1:0][SW-1:0] mem;
    logic [NREC-1:0][AW-1:0] rbase;
    logic [NREC-1:0][LW-1:0] rph;
    logic [NREC-1:0][LW-1:0] rpre;
    logic [NREC-1:0][LW-1:0] rlen;
    logic [IW-1:0] head;
    logic [IW-1:0] tail;
    logic [IW:0] cnt;
    logic [AW-1:0] last_end;
    logic [AW-1:0] base;
    logic [LW-1:0] ph;
    logic [LW-1:0] cph;
    logic [LW-1:0] cpre;
    logic [LW-1:0] len;
    logic [LW-1:0] pcnt;
    fwr_pkg::fwr_state_t st;
    logic saved;
    logic ext;
    logic trip_seen;
    logic pu_d;
    logic trip_d;
    logic bin_d;
    logic pend_p;
    logic pend_x;
    logic [TW-1:0] tcnt;
    fwr_pkg::fwr_mode_t mode;
    logic scope;
    logic xtrip;
    logic [LW-1:0] pre;
    logic [LW-1:0] post;
    logic [LW-1:0] maxl;
    logic [LW-1:0] ext_dur;
    logic [fwr_pkg::STS_W-1:0] sts;
    logic [fwr_pkg::STS_W-1:0] msk;
    logic [IW-1:0] rsel;
    logic [LW-1:0] sidx;
    logic [31:0] prdata;
    logic start;
    logic xfer;
  } fwr_st_t;

  fwr_st_t q;
  fwr_st_t d;

  logic tick;
  logic setup;
  logic acc;
  logic crit;
  logic commit;
  logic capr;
  logic [IW-1:0] ridx;
  logic [AW-1:0] raddr;
  logic [LW-1:0] roff;
  logic rvalid;
  logic [SW-1:0] rsmp;
  logic [31:0] rd;

  function automatic logic [LW-1:0] clampv(logic [31:0] v, int unsigned lo, int unsigned hi);
    if (v < lo) return LW'(lo);
    if (v > hi) return LW'(hi);
    return LW'(v);
  endfunction

  function automatic logic [AW-1:0] wadd(logic [AW-1:0] a, logic [LW-1:0] b);
    logic [AW:0] s;
    s = {1'b0, a} + (AW+1)'(b);
    if (s >= (AW+1)'(DEPTH)) s = s - (AW+1)'(DEPTH);
    return s[AW-1:0];
  endfunction

  function automatic logic mapped(logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= fwr_pkg::OFS_D2);
  endfunction

  assign tick = (q.tcnt == TW'(TICK_CYC - 1));
  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped(paddr_i);
  assign prdata_o = q.prdata;
  assign rec_active_o = (q.st != fwr_pkg::ST_IDLE);
  assign rec_start_o = q.start;
  assign xfer_req_o = q.xfer;
  assign irq_o = |(q.sts & q.msk);

  // Readout address of the selected record, oldest record is index 0
  assign ridx = q.tail + q.rsel;
  always_comb begin
    roff = q.sidx;
    if (q.sidx < q.rpre[ridx]) begin
      roff = q.rph[ridx] + q.sidx;
      if (roff >= q.rpre[ridx]) roff = roff - q.rpre[ridx];
    end
    raddr = wadd(q.rbase[ridx], roff);
  end
  assign rvalid = ((IW+1)'(q.rsel) < q.cnt) && (q.sidx < q.rlen[ridx]);
  assign rsmp = rvalid ? q.mem[raddr] : '0;

  always_comb begin
    rd = '0;
    case (paddr_i)
      fwr_pkg::OFS_CTRL: begin
        rd[1:0] = q.mode;
        rd[fwr_pkg::CTRL_SCOPE] = q.scope;
        rd[fwr_pkg::CTRL_XTRIP] = q.xtrip;
      end
      fwr_pkg::OFS_PRE: rd = 32'(q.pre);
      fwr_pkg::OFS_POST: rd = 32'(q.post);
      fwr_pkg::OFS_MAXL: rd = 32'(q.maxl);
      fwr_pkg::OFS_EXT: rd = 32'(q.ext_dur);
      fwr_pkg::OFS_STS: rd = 32'(q.sts);
      fwr_pkg::OFS_MASK: rd = 32'(q.msk);
      fwr_pkg::OFS_INFO: begin
        rd[IW:0] = q.cnt;
        rd[fwr_pkg::INFO_ACTIVE] = rec_active_o;
      end
      fwr_pkg::OFS_RSEL: rd = 32'(q.rsel);
      fwr_pkg::OFS_SIDX: rd = 32'(q.sidx);
      fwr_pkg::OFS_RLEN: rd = ((IW+1)'(q.rsel) < q.cnt) ? 32'(q.rlen[ridx]) : '0;
      fwr_pkg::OFS_D0: rd = {16'(rsmp[DW+:DW]), 16'(rsmp[0+:DW])};
      fwr_pkg::OFS_D1: rd = {16'(rsmp[3*DW+:DW]), 16'(rsmp[2*DW+:DW])};
      fwr_pkg::OFS_D2: rd = {16'(rsmp[5*DW+:DW]), 16'(rsmp[4*DW+:DW])};
      default: rd = '0;
    endcase
  end

  always_comb begin
    logic [AW-1:0] wa;
    logic [LW-1:0] len_n;
    logic [LW-1:0] tot_n;
    logic [LW-1:0] lenc;
    logic [LW-1:0] ph_n;
    logic [LW-1:0] pcnt_n;
    logic wr;
    wa = '0;
    len_n = q.len + 1'b1;
    tot_n = q.cpre + len_n;
    lenc = (tot_n > q.maxl) ? q.maxl : tot_n;
    ph_n = (q.ph + 1'b1 >= q.pre) ? '0 : q.ph + 1'b1;
    pcnt_n = q.pcnt + 1'b1;
    wr = 1'b0;
    commit = 1'b0;
    capr = 1'b0;
    d = q;
    d.start = 1'b0;
    d.xfer = 1'b0;
    d.tcnt = tick ? '0 : q.tcnt + 1'b1;
    d.pu_d = pickup_i;
    d.trip_d = trip_i;
    d.bin_d = bin_trig_i;
    // Trigger instant: pickup edge, or trip edge in start-on-trip mode
    if (q.mode == fwr_pkg::MODE_START_TRIP) begin
      if (trip_i & ~q.trip_d) d.pend_p = 1'b1;
    end else if (pickup_i & ~q.pu_d) begin
      d.pend_p = 1'b1;
    end
    if (bin_trig_i & ~q.bin_d) d.pend_x = 1'b1;
    // Span criterion of the running record
    if (q.ext) begin
      crit = (q.ext_dur == '0) ? bin_trig_i : (q.len < q.ext_dur);
    end else begin
      crit = ((q.mode == fwr_pkg::MODE_START_TRIP) ? trip_i : pickup_i) | (q.scope & reclose_i);
    end
    if (setup) d.prdata = rd;
    if (acc & pwrite_i) begin
      case (paddr_i)
        fwr_pkg::OFS_CTRL: begin
          if (pwdata_i[1:0] != 2'h3) d.mode = fwr_pkg::fwr_mode_t'(pwdata_i[1:0]);
          d.scope = pwdata_i[fwr_pkg::CTRL_SCOPE];
          d.xtrip = pwdata_i[fwr_pkg::CTRL_XTRIP];
          if (pwdata_i[fwr_pkg::CTRL_SWTRIG]) d.pend_x = 1'b1;
        end
        fwr_pkg::OFS_PRE: d.pre = clampv(pwdata_i, fwr_pkg::PRE_MIN_MS, fwr_pkg::PRE_MAX_MS);
        fwr_pkg::OFS_POST: d.post = clampv(pwdata_i, fwr_pkg::POST_MIN_MS, fwr_pkg::POST_MAX_MS);
        fwr_pkg::OFS_MAXL: d.maxl = clampv(pwdata_i, fwr_pkg::MAXL_MIN_MS, fwr_pkg::CAP_MS);
        fwr_pkg::OFS_EXT: begin
          d.ext_dur = (pwdata_i == '0) ? '0 : clampv(pwdata_i, fwr_pkg::EXT_MIN_MS, fwr_pkg::CAP_MS);
        end
        fwr_pkg::OFS_MASK: d.msk = pwdata_i[fwr_pkg::STS_W-1:0];
        fwr_pkg::OFS_RSEL: d.rsel = pwdata_i[IW-1:0];
        fwr_pkg::OFS_SIDX: d.sidx = pwdata_i[LW-1:0];
        default: d.msk = q.msk;
      endcase
    end
    if (acc & ~pwrite_i) begin
      // Only bits that were returned are cleared; later events stay set
      if (paddr_i == fwr_pkg::OFS_STS) d.sts = q.sts & ~q.prdata[fwr_pkg::STS_W-1:0];
      if (paddr_i == fwr_pkg::OFS_D2) d.sidx = q.sidx + 1'b1;
    end
    if (tick) begin
      wr = 1'b1;
      if (q.st == fwr_pkg::ST_IDLE) begin
        // Pre-trigger window circulates just past the newest record
        wa = wadd(q.last_end, q.ph);
        d.ph = ph_n;
        if (q.pend_p | q.pend_x) begin
          d.st = fwr_pkg::ST_FAULT;
          d.base = q.last_end;
          d.cpre = q.pre;
          d.cph = ph_n;
          d.len = '0;
          d.ext = ~q.pend_p;
          d.trip_seen = trip_i;
          d.saved = ~q.pend_p | (q.mode != fwr_pkg::MODE_SAVE_TRIP) | trip_i;
          d.start = 1'b1;
          d.pend_p = 1'b0;
          d.pend_x = 1'b0;
        end
      end else begin
        wa = wadd(q.base, q.cpre + q.len);
        d.len = len_n;
        d.pend_p = 1'b0;
        d.pend_x = 1'b0;
        if (trip_i) begin
          d.trip_seen = 1'b1;
          d.saved = 1'b1;
        end
        capr = (tot_n >= q.maxl);
        if (capr) begin
          commit = 1'b1;
        end else if (q.st == fwr_pkg::ST_FAULT) begin
          if (!crit) begin
            d.st = fwr_pkg::ST_POST;
            // The dropout sample is the first post sample
            d.pcnt = LW'(1);
          end
        end else if (crit & ~q.ext) begin
          d.st = fwr_pkg::ST_FAULT;
        end else begin
          d.pcnt = pcnt_n;
          if (pcnt_n >= q.post) commit = 1'b1;
        end
      end
    end
    if (wr) begin
      d.mem[wa] = {vol_l3_i, vol_l2_i, vol_l1_i, cur_l3_i, cur_l2_i, cur_l1_i};
      // Writing onto the oldest record's start retires it
      if ((d.cnt != '0) && (wa == d.rbase[d.tail])) begin
        d.tail = d.tail + 1'b1;
        d.cnt = d.cnt - 1'b1;
        d.sts[fwr_pkg::STS_DROP] = 1'b1;
      end
    end
    if (commit) begin
      d.st = fwr_pkg::ST_IDLE;
      d.ph = '0;
      if (d.saved) begin
        if (d.cnt == (IW+1)'(NREC)) begin
          d.tail = d.tail + 1'b1;
          d.sts[fwr_pkg::STS_DROP] = 1'b1;
        end else begin
          d.cnt = d.cnt + 1'b1;
        end
        d.rbase[d.head] = q.base;
        d.rph[d.head] = q.cph;
        d.rpre[d.head] = q.cpre;
        d.rlen[d.head] = lenc;
        d.head = d.head + 1'b1;
        d.last_end = wadd(q.base, lenc);
        d.sts[fwr_pkg::STS_DONE] = 1'b1;
        if (~q.ext & (~q.xtrip | d.trip_seen)) begin
          d.xfer = 1'b1;
          d.sts[fwr_pkg::STS_XFER] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.st <= fwr_pkg::ST_IDLE;
      q.mode <= fwr_pkg::MODE_SAVE_PU;
      q.pre <= LW'(fwr_pkg::PRE_DEF_MS);
      q.post <= LW'(fwr_pkg::POST_DEF_MS);
      q.maxl <= LW'(fwr_pkg::MAXL_DEF_MS);
      q.ext_dur <= LW'(fwr_pkg::EXT_DEF_MS);
    end else begin
      q <= d;
    end
  end

  a_tick_count: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !tick |=> q.tcnt == TW'($past(q.tcnt) + 1'b1)) else $error("sample divider skipped");
  a_sample_advance: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tick && q.st != fwr_pkg::ST_IDLE && !commit) |=> q.len == LW'($past(q.len) + 1'b1))
    else $error("active record did not take a sample");
  a_store_count: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    q.cnt <= (IW+1)'(NREC)) else $error("record count above limit");
  a_record_cap: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    q.maxl <= LW'(fwr_pkg::CAP_MS) && q.maxl >= LW'(fwr_pkg::MAXL_MIN_MS)) else $error("max length out of range");
  a_len_limit: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (q.st != fwr_pkg::ST_IDLE && q.cpre < q.maxl) |-> (q.cpre + q.len) < q.maxl)
    else $error("record ran past max length");
  a_full_roll: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (commit && d.saved && q.cnt == (IW+1)'(NREC)) |=> q.cnt == (IW+1)'(NREC) && q.sts[fwr_pkg::STS_DROP])
    else $error("full store did not roll over");
  a_active_end: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(rec_active_o) |-> $past(commit)) else $error("recording ended without commit");
  a_start_active: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rec_start_o |-> rec_active_o && q.len == '0) else $error("start without active record");
  a_pre_origin: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rec_start_o |-> q.cpre == $past(q.pre) && q.base == $past(q.last_end)) else $error("pre window misplaced");
  a_fault_exit: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tick && q.st == fwr_pkg::ST_FAULT && !crit && !capr) |=> q.st == fwr_pkg::ST_POST)
    else $error("dropout did not start post interval");
  a_post_bound: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    q.st == fwr_pkg::ST_POST |-> q.pcnt < q.post) else $error("post interval overran");
  a_ext_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tick && q.st == fwr_pkg::ST_FAULT && q.ext && q.ext_dur == '0 && bin_trig_i && !capr)
    |=> q.st == fwr_pkg::ST_FAULT) else $error("infinite capture ended early");
  a_ext_dur: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (q.st == fwr_pkg::ST_FAULT && q.ext && q.ext_dur != '0) |-> q.len <= q.ext_dur)
    else $error("external capture too long");
  a_reclose_span: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tick && q.st != fwr_pkg::ST_IDLE && !q.ext && q.scope && reclose_i && !capr)
    |=> q.st == fwr_pkg::ST_FAULT) else $error("disturbance record cut in dead time");
  a_xfer_trip: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    xfer_req_o |-> !q.ext && (!q.xtrip || q.trip_seen)) else $error("transfer request without cause");
  a_trig_take: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tick && q.st == fwr_pkg::ST_IDLE && q.pend_p) |=> rec_start_o && !q.ext) else $error("trigger not taken");
endmodule
`default_nettype wire

// file: tb/fwr_prot_model.sv
// Behavioural protection pickup and binary-input source facing the recorder
`timescale 1ns/1ps
`default_nettype none
module fwr_prot_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fault_i,
  input wire logic bin_go_i,
  input wire logic trip_en_i,
  input wire logic recl_en_i,
  input wire logic [15:0] hold_i,
  output logic pickup_o,
  output logic trip_o,
  output logic reclose_o,
  output logic bin_trig_o
);
  int f_cnt;
  int b_cnt;
  int h;
  logic t_en;
  logic r_en;
  // Pickup for h cycles, then optionally a dead time and a second pickup
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      f_cnt <= 0;
      b_cnt <= 0;
      h <= 0;
      t_en <= 1'b0;
      r_en <= 1'b0;
    end else begin
      if (fault_i) begin
        f_cnt <= 1;
        h <= int'(hold_i);
        t_en <= trip_en_i;
        r_en <= recl_en_i;
      end else if (f_cnt != 0) begin
        f_cnt <= (f_cnt >= 3 * h) ? 0 : f_cnt + 1;
      end
      if (bin_go_i) begin
        b_cnt <= int'(hold_i);
      end else if (b_cnt != 0) begin
        b_cnt <= b_cnt - 1;
      end
    end
  end
  assign pickup_o = f_cnt != 0 && (f_cnt <= h || (r_en && f_cnt > 2 * h));
  assign trip_o = t_en && f_cnt != 0 && f_cnt <= h / 2;
  assign reclose_o = r_en && f_cnt > h && f_cnt <= 2 * h;
  assign bin_trig_o = b_cnt != 0;
endmodule
`default_nettype wire

// file: tb/fault_waveform_recorder_test.sv
// Self-checking testbench of the fault waveform recorder
`timescale 1ns/1ps
`default_nettype none
module fault_waveform_recorder_test;
  localparam int unsigned TK = 8;
  logic clk, rst, psel, penable, pwrite, fault, bin_go, trip_en, recl_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, rec_active, rec_start, xfer_req, irq, err;
  logic pickup, trip, reclose, bin_trig;
  logic [15:0] smp [6];
  logic [15:0] hold;
  int err_count, checked, cycles, starts, xfers, cnt, hs, n0, x0;

  fwr_top #(.TICK_CYC(TK), .DEPTH(2048)) fwr_top_inst (.core_clk_i(clk), .sys_rst_i(rst),
    .cur_l1_i(smp[0]), .cur_l2_i(smp[1]), .cur_l3_i(smp[2]), .vol_l1_i(smp[3]), .vol_l2_i(smp[4]),
    .vol_l3_i(smp[5]), .pickup_i(pickup), .trip_i(trip), .reclose_i(reclose), .bin_trig_i(bin_trig),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rec_active_o(rec_active),
    .rec_start_o(rec_start), .xfer_req_o(xfer_req), .irq_o(irq));
  fwr_prot_model fwr_prot_model_inst (.clk_i(clk), .rst_i(rst), .fault_i(fault), .bin_go_i(bin_go),
    .trip_en_i(trip_en), .recl_en_i(recl_en), .hold_i(hold), .pickup_o(pickup), .trip_o(trip),
    .reclose_o(reclose), .bin_trig_o(bin_trig));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (rec_start === 1'b1) starts++;
    if (xfer_req === 1'b1) xfers++;
    if (cycles == 80000) begin
      err_count++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] exp_len(input int pre, input int span, input int post, input int maxl);
    return (pre + span + post > maxl) ? maxl : pre + span + post;
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go(input logic b, input int h, input logic t, input logic r);
    hold <= 16'(h);
    trip_en <= t;
    recl_en <= r;
    fault <= ~b;
    bin_go <= b;
    @(posedge clk);
    fault <= 1'b0;
    bin_go <= 1'b0;
  endtask

  task automatic wait_rec(input int lim);
    cnt = 0;
    while (rec_active !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      cnt++;
    end
    while (rec_active === 1'b1) begin
      @(posedge clk);
      cnt++;
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic rlen_of(input int idx);
    apb(1'b1, fwr_pkg::OFS_RSEL, 32'(idx));
    apb(1'b0, fwr_pkg::OFS_RLEN, 32'h0);
  endtask

  initial begin
    {rst, psel, penable, pwrite, fault, bin_go, trip_en, recl_en} = 8'hff;
    {psel, penable, pwrite, fault, bin_go, trip_en, recl_en} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hold = 16'h0;
    void'($urandom(32'h6aea));
    foreach (smp[k]) smp[k] = 16'($urandom);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, fwr_pkg::OFS_PRE, 32'h0);
    check("pre default", q, 32'd250);
    apb(1'b0, fwr_pkg::OFS_POST, 32'h0);
    check("post default", q, 32'd100);
    apb(1'b0, fwr_pkg::OFS_MAXL, 32'h0);
    check("maxl default", q, 32'd2000);
    apb(1'b0, fwr_pkg::OFS_EXT, 32'h0);
    check("ext default", q, 32'd500);
    apb(1'b0, 8'h3c, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, fwr_pkg::OFS_PRE, 32'd10);
    apb(1'b0, fwr_pkg::OFS_PRE, 32'h0);
    check("pre clamp", q, 32'd50);
    apb(1'b1, fwr_pkg::OFS_POST, 32'd50);
    apb(1'b1, fwr_pkg::OFS_MAXL, 32'd300);
    apb(1'b1, fwr_pkg::OFS_EXT, 32'd100);
    apb(1'b1, fwr_pkg::OFS_MASK, 32'h1);
    // Binary input, then serial trigger: fixed external duration
    go(1'b1, 16, 1'b0, 1'b0);
    wait_rec(200);
    check("irq on done", {31'h0, irq}, 32'h1);
    apb(1'b0, fwr_pkg::OFS_STS, 32'h0);
    check("done bit", {31'h0, q[fwr_pkg::STS_DONE]}, 32'h1);
    @(negedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, fwr_pkg::OFS_CTRL, 32'h10);
    wait_rec(200);
    for (int r = 0; r < 2; r++) begin
      rlen_of(r);
      check("ext len", q, exp_len(50, 100, 50, 300));
    end
    apb(1'b1, fwr_pkg::OFS_SIDX, 32'd100);
    apb(1'b0, fwr_pkg::OFS_D0, 32'h0);
    check("d0", q, {smp[1], smp[0]});
    apb(1'b0, fwr_pkg::OFS_D1, 32'h0);
    check("d1", q, {smp[3], smp[2]});
    apb(1'b0, fwr_pkg::OFS_D2, 32'h0);
    check("d2", q, {smp[5], smp[4]});
    // Infinite duration: level of the input, capped at the maximum length
    apb(1'b1, fwr_pkg::OFS_EXT, 32'h0);
    hs = 40 + $urandom % 40;
    go(1'b1, hs * TK, 1'b0, 1'b0);
    wait_rec(200);
    rlen_of(2);
    // Trigger tick and its phase cost one or two span samples
    check("level len", {31'h0, q >= hs + 98 && q <= hs + 99}, 32'h1);
    go(1'b1, 500 * TK, 1'b0, 1'b0);
    wait_rec(200);
    rlen_of(3);
    check("max len", q, exp_len(50, 500, 50, 300));
    // Save on trip: without trip nothing kept, with trip kept and transferred
    apb(1'b1, fwr_pkg::OFS_MAXL, 32'd5000);
    apb(1'b1, fwr_pkg::OFS_CTRL, 32'(fwr_pkg::MODE_SAVE_TRIP));
    x0 = xfers;
    go(1'b0, 60 * TK, 1'b0, 1'b0);
    wait_rec(200);
    apb(1'b0, fwr_pkg::OFS_INFO, 32'h0);
    check("no trip count", {28'h0, q[3:0]}, 32'd4);
    hs = 40 + $urandom % 60;
    go(1'b0, hs * TK, 1'b1, 1'b0);
    wait_rec(200);
    check("xfer pulses", 32'(xfers - x0), 32'd1);
    rlen_of(4);
    check("fault len", {31'h0, q >= hs + 98 && q <= hs + 99}, 32'h1);
    // Start on trip: pickup alone does not start a record
    apb(1'b1, fwr_pkg::OFS_CTRL, 32'(fwr_pkg::MODE_START_TRIP));
    n0 = starts;
    go(1'b0, 40 * TK, 1'b0, 1'b0);
    repeat (1000) @(posedge clk);
    check("trip start", 32'(starts - n0), 32'd0);
    go(1'b0, 40 * TK, 1'b1, 1'b0);
    wait_rec(200);
    check("trip start", 32'(starts - n0), 32'd1);
    // Reclose gap: two records in single scope, one in whole scope
    for (int s = 0; s < 2; s++) begin
      // Transfer only after trip: pickup-only records raise no request
      apb(1'b1, fwr_pkg::OFS_CTRL, 32'((s << fwr_pkg::CTRL_SCOPE) | (1 << fwr_pkg::CTRL_XTRIP)));
      n0 = starts;
      x0 = xfers;
      go(1'b0, 60 * TK, 1'b0, 1'b1);
      wait_rec(200);
      wait_rec(1000);
      check("scope records", 32'(starts - n0), s ? 32'd1 : 32'd2);
      check("xfer after trip", 32'(xfers - x0), 32'd0);
    end
    apb(1'b0, fwr_pkg::OFS_INFO, 32'h0);
    check("store full", {28'h0, q[3:0]}, 32'd8);
    apb(1'b0, fwr_pkg::OFS_STS, 32'h0);
    check("drop bit", {31'h0, q[fwr_pkg::STS_DROP]}, 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
